// *** verilog/spo_map.vh ***
// constants for the synchronous serial position output port
// assumes a 25 MHz system clock (40 ns period)
`ifndef SPO_MAP_VH
`define SPO_MAP_VH

// =====================================================================
// frame layout
`define SPO_POS_W_SHORT   24
`define SPO_POS_W_LONG    32
`define SPO_FRAME_SHORT   25
`define SPO_FRAME_LONG    33

// =====================================================================
// monoflop timing
`define SPO_CLK_MHZ       25
`define SPO_MONO_US_0     5
`define SPO_MONO_US_1     10
`define SPO_MONO_US_2     20
`define SPO_MONO_CYC_0    (`SPO_MONO_US_0 * `SPO_CLK_MHZ)
`define SPO_MONO_CYC_1    (`SPO_MONO_US_1 * `SPO_CLK_MHZ)
`define SPO_MONO_CYC_2    (`SPO_MONO_US_2 * `SPO_CLK_MHZ)

// monoflop select codes
`define SPO_MONO_SEL_5US  2'h0
`define SPO_MONO_SEL_10US 2'h1
`define SPO_MONO_SEL_20US 2'h2

`endif

// *** verilog/spo_sync.v ***
// two-flop synchroniser for one level from outside the sys_clk domain
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/1ns

module spo_sync #(
	parameter RST_VAL = 1'b1
) (
	input  wire sys_clk,
	input  wire srst,
	input  wire async_in,
	output reg  sync_out
);

	reg meta_r;

	// =================================================================
	// synchroniser chain; meta_r feeds only sync_out
	always @(posedge sys_clk) begin
		if (srst) begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// *** verilog/spo_top.v ***
// synchronous serial position output port of an absolute encoder
// assumes the controller drives ser_clk_in (idle high) and a position source on sys_clk
`timescale 1ns/1ns
`include "spo_map.vh"

module spo_top #(
	parameter POS_W = `SPO_POS_W_LONG
) (
	input  wire             sys_clk,
	input  wire             srst,
	input  wire             ser_clk_in,
	input  wire [POS_W-1:0] position,
	input  wire             long_frame,
	input  wire [1:0]       mono_sel,
	input  wire             crit_error,
	output reg              serial_data_out,
	output reg              busy
);

	// states, one-hot
	localparam ST_IDLE  = 3'h1;
	localparam ST_SHIFT = 3'h2;
	localparam ST_HOLD  = 3'h4;

	localparam [11:0] MONO_0 = `SPO_MONO_CYC_0;
	localparam [11:0] MONO_1 = `SPO_MONO_CYC_1;
	localparam [11:0] MONO_2 = `SPO_MONO_CYC_2;
	localparam [5:0]  FR_S   = `SPO_FRAME_SHORT;
	localparam [5:0]  FR_L   = `SPO_FRAME_LONG;

	wire             clk_s;
	reg              clk_d_r;
	reg  [2:0]       state_r;
	reg  [32:0]      shreg_r;
	reg  [5:0]       bitcnt_r;
	reg  [5:0]       frame_len_r;
	reg  [11:0]      mono_r;
	reg  [11:0]      mono_load;
	reg              err_r;
	reg  [32:0]      frame_img;
	wire             fall;
	wire             rise;

	// =================================================================
	// link clock sampling
	spo_sync #(
		.RST_VAL (1'b1)
	) u_clk_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (ser_clk_in),
		.sync_out (clk_s)
	);

	always @(posedge sys_clk) begin
		if (srst)
			clk_d_r <= 1'b1;
		else
			clk_d_r <= clk_s;
	end

	assign fall = clk_d_r & ~clk_s;
	assign rise = ~clk_d_r & clk_s;

	// =================================================================
	// timeout reload and frame image
	always @* begin
		case (mono_sel)
			`SPO_MONO_SEL_5US:  mono_load = MONO_0;
			`SPO_MONO_SEL_10US: mono_load = MONO_1;
			default:            mono_load = MONO_2;
		endcase
		// leading zero then msb-first binary, left aligned at bit 32
		frame_img = 33'h0;
		if (long_frame)
			frame_img[31:0] = position[31:0];
		else
			frame_img[31:8] = position[POS_W-1 -: 24];
	end

	// =================================================================
	// sticky critical error, cleared only by reset
	always @(posedge sys_clk) begin
		if (srst)
			err_r <= 1'b0;
		else if (crit_error)
			err_r <= 1'b1;
	end

	// =================================================================
	// frame state machine
	always @(posedge sys_clk) begin
		if (srst) begin
			state_r     <= ST_IDLE;
			shreg_r     <= 33'h0;
			bitcnt_r    <= 6'h0;
			frame_len_r <= FR_L;
			mono_r      <= 12'h0;
		end else begin
			// any clock edge retriggers the monoflop
			if (fall | rise)
				mono_r <= mono_load;
			else if (mono_r != 12'h0)
				mono_r <= mono_r - 12'h1;
			case (state_r)
				ST_IDLE: begin
					if (fall) begin
						shreg_r     <= frame_img;
						frame_len_r <= long_frame ? FR_L : FR_S;
						bitcnt_r    <= 6'h0;
						state_r     <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (rise) begin
						// rotate within the frame so a full frame restores the image
						if (frame_len_r == FR_L)
							shreg_r <= {shreg_r[31:0], shreg_r[32]};
						else
							shreg_r[32:8] <= {shreg_r[31:8], shreg_r[32]};
						bitcnt_r <= bitcnt_r + 6'h1;
					end else if (fall && bitcnt_r == frame_len_r) begin
						state_r <= ST_HOLD;
					end else if (mono_r == 12'h0 && !(fall | rise)) begin
						state_r <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					// the return-to-idle rise only retriggers the timer
					if (fall) begin
						// new clocks inside the timeout: same frame again, no capture
						bitcnt_r <= 6'h0;
						state_r  <= ST_SHIFT;
					end else if (mono_r == 12'h0 && !(fall | rise)) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// =================================================================
	// data line: error high, idle high, frame bit or hold low
	always @(posedge sys_clk) begin
		if (srst) begin
			serial_data_out <= 1'b1;
			busy            <= 1'b0;
		end else begin
			busy <= (state_r != ST_IDLE);
			if (err_r)
				serial_data_out <= 1'b1;
			else if (state_r == ST_IDLE)
				serial_data_out <= 1'b1;
			else if (state_r == ST_HOLD)
				serial_data_out <= 1'b0;
			else if (bitcnt_r == 6'h0)
				serial_data_out <= 1'b0;
			else
				serial_data_out <= (frame_len_r == FR_L) ? shreg_r[0] : shreg_r[8];
		end
	end

endmodule

// *** tb/spo_properties.sv ***
// port checker for spo_top
// assumes link edges at least 4 sys_clk apart
`timescale 1ns/1ns
module spo_props (
	input wire       sys_clk,
	input wire       srst,
	input wire       ser_clk_in,
	input wire [1:0] mono_sel,
	input wire       crit_error,
	input wire       serial_data_out,
	input wire       busy
);
	// ====
	// cycles since last pin edge, sticky error
	reg [9:0] cnt_r;
	reg       pin_r;
	reg       err_r;
	wire [9:0] lim = mono_sel == 2'h0 ? 10'h7d : mono_sel == 2'h1 ? 10'hfa : 10'h1f4;
	always @(posedge sys_clk) begin
		pin_r <= ser_clk_in;
		cnt_r <= (srst || pin_r != ser_clk_in) ? 10'h0 : cnt_r + {9'h0, cnt_r != 10'h3ff};
		err_r <= !srst && (err_r || crit_error);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ====
	// properties
	sticky_err_a: assert property (err_r |=> serial_data_out)
		else $error("data low under error");
	idle_high_a: assert property (!busy && !$past(busy) |-> serial_data_out)
		else $error("data low in idle");
	lead_zero_a: assert property ($rose(busy) && !err_r |-> ##[0:2] !serial_data_out)
		else $error("no leading zero");
	start_fall_a: assert property ($rose(busy) |-> !$past(ser_clk_in, 2))
		else $error("start without fall");
	timeout_max_a: assert property (busy |-> cnt_r < lim + 10'h8)
		else $error("timeout late");
	timeout_min_a: assert property ($fell(busy) |-> cnt_r >= lim)
		else $error("timeout early");
	hold_low_a: assert property (busy && cnt_r > 10'hc && !err_r |-> !serial_data_out)
		else $error("hold not low");
	bit_stable_a: assert property (cnt_r > 10'h6 && cnt_r < lim && !err_r |-> $stable(serial_data_out))
		else $error("bit moved");
endmodule
bind spo_top spo_props u_props (.sys_clk(sys_clk), .srst(srst), .ser_clk_in(ser_clk_in),
	.mono_sel(mono_sel), .crit_error(crit_error), .serial_data_out(serial_data_out), .busy(busy));

// *** tb/spo_ctrl.sv ***
// controller model: drives link clock, samples data
// assumes data settles within half a link period
`timescale 1ns/1ns
module spo_ctrl (
	output reg  ser_clk,
	input  wire sdo
);
	// idle high, still between frames
	initial ser_clk = 1'b1;
	// ====
	// one readout of n bits, 320 ns period
	task frame(input integer n, output reg [32:0] q);
		integer k;
		begin
			q = 33'h0;
			ser_clk = 1'b0;
			for (k = 0; k < n; k = k + 1) begin
				#160 ser_clk = 1'b1;
				#160 q = {q[31:0], sdo};
				ser_clk = 1'b0;
			end
			#160 ser_clk = 1'b1;
		end
	endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for spo_top
// assumes spo_ctrl on the link side
`timescale 1ns/1ns
module tb_top;
	reg         sys_clk = 1'b0;
	reg         srst = 1'b1;
	reg  [31:0] position = 32'hb3c5a71e;
	reg         long_frame = 1'b1;
	reg  [1:0]  mono_sel = 2'h0;
	reg         crit_error = 1'b0;
	wire        ser_clk_in;
	wire        serial_data_out;
	wire        busy;
	integer     errors = 0;
	integer     checked = 0;
	integer     cyc = 0;
	integer     i;
	reg  [32:0] q;
	// ====
	// clock and cycle ceiling
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			complete_run;
		end
	end
	spo_top DUT (.sys_clk(sys_clk), .srst(srst), .ser_clk_in(ser_clk_in), .position(position),
		.long_frame(long_frame), .mono_sel(mono_sel), .crit_error(crit_error),
		.serial_data_out(serial_data_out), .busy(busy));
	spo_ctrl u_ctrl (.ser_clk(ser_clk_in), .sdo(serial_data_out));
	// ====
	// helpers
	task wt(input integer n);
		begin
			repeat (n) @(posedge sys_clk);
			#1;
		end
	endtask
	task cmp(input [63:0] nm, input [32:0] exp, input [32:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("FAIL %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	// ====
	// scenarios
	task t_frame(input lf, input [1:0] sel, input integer lim);
		begin
			long_frame = lf;
			mono_sel = sel;
			u_ctrl.frame(lf ? 33 : 25, q);
			cmp("frame", lf ? {1'b0, position} : {9'h0, position[31:8]}, q);
			wt(lim - 20);
			cmp("hold", 33'h0, serial_data_out);
			wt(40);
			cmp("idle", 33'h1, {busy, serial_data_out});
		end
	endtask
	task t_repeat(input lf);
		reg [32:0] first;
		begin
			long_frame = lf;
			mono_sel = 2'h0;
			u_ctrl.frame(lf ? 33 : 25, first);
			position = ~position;
			wt(20);
			u_ctrl.frame(lf ? 33 : 25, q);
			cmp("repeat", first, q);
			cmp("old", lf ? {1'b0, ~position} : {9'h0, ~position[31:8]}, q);
			wt(140);
		end
	endtask
	task t_error;
		begin
			fork
				u_ctrl.frame(33, q);
				begin
					wt(40);
					crit_error = 1'b1;
					wt(1);
					crit_error = 1'b0;
				end
			join
			cmp("errbits", 33'hffff, q[15:0]);
			wt(600);
			cmp("errhold", 33'h1, serial_data_out);
		end
	endtask
	task complete_run;
		begin
			if (errors == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		wt(20);
		srst = 1'b0;
		wt(4);
		for (i = 0; i < 4; i = i + 1)
			t_frame(i[0], i[1:0], i == 0 ? 125 : i == 1 ? 250 : 500);
		t_repeat(1'b1);
		t_repeat(1'b0);
		t_frame(1'b1, 2'h0, 125);
		t_error;
		srst = 1'b1;
		wt(2);
		srst = 1'b0;
		wt(4);
		t_frame(1'b0, 2'h2, 500);
		complete_run;
	end
endmodule
